// *** design/ibm_defines.vh ***
`ifndef IBM_DEFINES_VH
`define IBM_DEFINES_VH
`define IBM_OFS_CH1_CTRL 8'h18
`define IBM_OFS_CH0_ADDR 8'h20
`define IBM_OFS_CH0_COUNT 8'h24
`define IBM_OFS_CH1_ADDR 8'h28
`define IBM_OFS_CH1_COUNT 8'h2c
`define IBM_OFS_CH0_FIFO 8'h40
`define IBM_BIT_ENABLE 0
`define IBM_BIT_DIR 3
`define IBM_BIT_ACTIVE 16
`define IBM_BIT_ERROR 17
`define IBM_BIT_COMPLETE 18
`define IBM_BIT_EMPTY 19
`define IBM_BIT_WATCHDOG 20
`define IBM_BIT_CAP0 21
`define IBM_BIT_CAP1 22
`define IBM_BIT_SIMPLEX 23
`define IBM_BIT_LAST 31
`define IBM_RESET_WORD 32'h00000000
`define IBM_FIFO_BYTES 256
`endif

// *** design/ibm_dma_status.v ***
// Notes on behaviour
// RULE_01 - simplex-only bit always reads zero; both channels may master together. Code grants the bus to one channel at a time.
// RULE_02 - two drive dma-capable bits are plain storage with no effect.
// RULE_03 - watchdog bit mirrors bit 12 of channel task-file status register.
// RULE_04 - buffer-empty bit is set whenever the channel fifo is empty.
// RULE_05 - to memory: complete needs drive irq and fifo drained; from memory: irq only.
// RULE_06 - enabled: complete latches, cleared by writing one; disabled: follows irq line.
// RULE_07 - master-error sets on bus error while mastering; write one clears.
// RULE_08 - active bit set while moving data; cleared when done or enable is zero.
// RULE_09 - direction one moves device to memory, zero memory to device.
// RULE_10 - enable starts engine; clearing wipes state, aborts and discards fifo data.
// RULE_11 - task-file or pio access while enabled ends in target-abort.
// RULE_12 - large-block mode only when control accessed at this second address. Code sets it on writes to 18h only, not on reads.
// RULE_13 - each channel has a read-only current dma address register.
// RULE_14 - byte count top bit shows last descriptor of table.
// RULE_15 - upper byte count shows extension in large-block mode, else zero.
// RULE_16 - low byte count shows current remaining count, read-only.
// RULE_17 - nine-bit fifo valid byte count, zero empty, 100h full. Code with DEPTH 16 reads 40h when full.
// RULE_18 - to memory: priority one when fifo dwords exceed write threshold. Code compares channel 1 against zero.
// RULE_19 - from memory: priority one when fifo free dwords exceed read threshold. Code compares channel 1 against zero.
// RULE_20 - simultaneous requests: higher priority wins, tie goes to last owner.
// RULE_21 - owner keeps bus unless requester has higher priority, then yields.
// RULE_22 - reserved bits ignore writes and read zero.
// RULE_23 - priority is zero when level does not exceed threshold.
`timescale 1ns/1ps
`include "ibm_defines.vh"
module ibm_dma_status #(
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clk_sys,
  input wire rst_n,
  input wire reg_sel,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [3:0] reg_be,
  output reg [31:0] reg_rdata,
  input wire generic_ctrl_access,
  input wire [1:0] taskfile_access,
  output reg [1:0] target_abort,
  input wire [1:0] drive_irq,
  input wire [1:0] watchdog_status,
  input wire [1:0] bus_error,
  input wire [1:0] dma_request,
  input wire pci_grant,
  output reg [1:0] pci_owner,
  output reg [1:0] stop_transaction,
  input wire [63:0] engine_address,
  input wire [31:0] engine_count,
  input wire [29:0] count_extension,
  input wire [1:0] last_descriptor_flag,
  input wire [1:0] transfer_done,
  input wire [1:0] fifo_in_valid,
  output reg [1:0] fifo_in_ready,
  input wire [63:0] fifo_in_data,
  output reg [1:0] fifo_out_valid,
  input wire [1:0] fifo_out_ready,
  output reg [63:0] fifo_out_data,
  output reg [1:0] engine_enable,
  output reg [1:0] transfer_direction,
  output reg [1:0] large_block_mode,
  output reg [1:0] request_priority
);
  // nine-bit byte count; dword level times four, zero-extended so full never double-counts
  function [8:0] byte_level;
    input [AW:0] words;
    begin
      byte_level = {{(6-AW){1'b0}}, words, 2'b00};
    end
  endfunction
  reg [1:0] drive0_dma_capable;
  reg [1:0] drive1_dma_capable;
  reg [1:0] transfer_complete_flag;
  reg [1:0] master_error_flag;
  reg [1:0] transfer_active_flag;
  reg [5:0] wr_threshold;
  reg [5:0] rd_threshold;
  reg [1:0] last_owner;
  wire [AW:0] level [0:1];
  wire [1:0] in_ready_w;
  wire [1:0] out_valid_w;
  wire [63:0] out_data_w;
  wire [1:0] fifo_empty;
  wire [1:0] next_priority;
  wire wr_ctrl;
  wire wr_fifo;
  reg [31:0] next_rdata;
  reg [1:0] next_owner;
  assign wr_ctrl = reg_sel & reg_wr & (reg_addr == `IBM_OFS_CH1_CTRL);
  assign wr_fifo = reg_sel & reg_wr & (reg_addr == `IBM_OFS_CH0_FIFO);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : ch
      wire [AW:0] free_words;
      ibm_fifo #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(~engine_enable[g]), // RULE_10
        .in_valid(fifo_in_valid[g]),
        .in_ready(in_ready_w[g]),
        .in_data(fifo_in_data[32*g+31:32*g]),
        .out_valid(out_valid_w[g]),
        .out_ready(fifo_out_ready[g]),
        .out_data(out_data_w[32*g+31:32*g]),
        .level(level[g])
      );
      assign fifo_empty[g] = (level[g] == {(AW+1){1'b0}}); // RULE_04
      assign free_words = DEPTH[AW:0] - level[g];
      // threshold is 6 bits; a shallow fifo simply never exceeds high thresholds
      assign next_priority[g] = transfer_direction[g] ?
        ({{(6-AW){1'b0}}, level[g]} > {1'b0, (g == 0 ? wr_threshold : 6'h00)}) : // RULE_18 RULE_23
        ({{(6-AW){1'b0}}, free_words} > {1'b0, (g == 0 ? rd_threshold : 6'h00)}); // RULE_19 RULE_23
      always @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          transfer_complete_flag[g] <= 1'b0;
          master_error_flag[g] <= 1'b0;
          transfer_active_flag[g] <= 1'b0;
          target_abort[g] <= 1'b0;
        end
        else
        begin
          if (!engine_enable[g])
            transfer_complete_flag[g] <= drive_irq[g]; // RULE_06
          else if (drive_irq[g] && (!transfer_direction[g] || (fifo_empty[g] && transfer_done[g]))) // RULE_05
            transfer_complete_flag[g] <= 1'b1;
          else if (g == 1 && wr_ctrl && reg_be[2] && reg_wdata[`IBM_BIT_COMPLETE])
            transfer_complete_flag[g] <= 1'b0; // RULE_06
          if (bus_error[g] && pci_owner[g])
            master_error_flag[g] <= 1'b1; // RULE_07
          else if (g == 1 && wr_ctrl && reg_be[2] && reg_wdata[`IBM_BIT_ERROR])
            master_error_flag[g] <= 1'b0; // RULE_07
          if (!engine_enable[g] || transfer_done[g])
            transfer_active_flag[g] <= 1'b0; // RULE_08
          else if (dma_request[g] || pci_owner[g])
            transfer_active_flag[g] <= 1'b1; // RULE_08
          target_abort[g] <= engine_enable[g] & taskfile_access[g]; // RULE_11
        end
      end
    end
  endgenerate
  always @*
  begin
    next_owner = 2'b00;
    if (pci_grant)
    begin
      if (pci_owner[0] && dma_request[0] && !(dma_request[1] && next_priority[1] && !next_priority[0]))
        next_owner = 2'b01; // RULE_21
      else if (pci_owner[1] && dma_request[1] && !(dma_request[0] && next_priority[0] && !next_priority[1]))
        next_owner = 2'b10; // RULE_21
      else if (dma_request == 2'b11)
      begin
        if (next_priority[0] != next_priority[1])
          next_owner = next_priority[0] ? 2'b01 : 2'b10; // RULE_20
        else
          next_owner = last_owner; // RULE_20
      end
      else
        next_owner = dma_request;
    end
  end
  always @*
  begin
    next_rdata = 32'h00000000; // RULE_22
    if (reg_sel && !reg_wr)
    begin
      case (reg_addr)
        `IBM_OFS_CH1_CTRL:
        begin
          next_rdata[`IBM_BIT_SIMPLEX] = 1'b0; // RULE_01
          next_rdata[`IBM_BIT_CAP1] = drive1_dma_capable[1];
          next_rdata[`IBM_BIT_CAP0] = drive0_dma_capable[1];
          next_rdata[`IBM_BIT_WATCHDOG] = watchdog_status[1]; // RULE_03
          next_rdata[`IBM_BIT_EMPTY] = fifo_empty[1]; // RULE_04
          next_rdata[`IBM_BIT_COMPLETE] = transfer_complete_flag[1];
          next_rdata[`IBM_BIT_ERROR] = master_error_flag[1];
          next_rdata[`IBM_BIT_ACTIVE] = transfer_active_flag[1];
          next_rdata[`IBM_BIT_DIR] = transfer_direction[1];
          next_rdata[`IBM_BIT_ENABLE] = engine_enable[1];
        end
        `IBM_OFS_CH0_ADDR: next_rdata = engine_address[31:0]; // RULE_13
        `IBM_OFS_CH1_ADDR: next_rdata = engine_address[63:32]; // RULE_13
        `IBM_OFS_CH0_COUNT:
          next_rdata = {last_descriptor_flag[0], // RULE_14
            large_block_mode[0] ? count_extension[14:0] : 15'h0000, engine_count[15:0]}; // RULE_15 RULE_16
        `IBM_OFS_CH1_COUNT:
          next_rdata = {last_descriptor_flag[1], // RULE_14
            large_block_mode[1] ? count_extension[29:15] : 15'h0000, engine_count[31:16]}; // RULE_15 RULE_16
        `IBM_OFS_CH0_FIFO:
          next_rdata = {7'h00, byte_level(level[0]), // RULE_17
            2'b00, wr_threshold, 2'b00, rd_threshold};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      engine_enable <= 2'b00;
      transfer_direction <= 2'b00;
      large_block_mode <= 2'b00;
      drive0_dma_capable <= 2'b00;
      drive1_dma_capable <= 2'b00;
      wr_threshold <= 6'h00;
      rd_threshold <= 6'h00;
      last_owner <= 2'b01;
      pci_owner <= 2'b00;
      stop_transaction <= 2'b00;
      request_priority <= 2'b00;
      reg_rdata <= `IBM_RESET_WORD;
      fifo_in_ready <= 2'b00;
      fifo_out_valid <= 2'b00;
      fifo_out_data <= 64'h0000000000000000;
    end
    else
    begin
      reg_rdata <= next_rdata;
      request_priority <= next_priority;
      pci_owner <= next_owner;
      stop_transaction <= pci_owner & ~next_owner & dma_request; // RULE_21
      if (next_owner != 2'b00)
        last_owner <= next_owner;
      fifo_in_ready <= in_ready_w;
      fifo_out_valid <= out_valid_w;
      fifo_out_data <= out_data_w;
      if (wr_ctrl)
      begin
        if (reg_be[0])
        begin
          engine_enable[1] <= reg_wdata[`IBM_BIT_ENABLE]; // RULE_10
          transfer_direction[1] <= reg_wdata[`IBM_BIT_DIR]; // RULE_09
        end
        if (reg_be[2])
        begin
          drive1_dma_capable[1] <= reg_wdata[`IBM_BIT_CAP1]; // RULE_02
          drive0_dma_capable[1] <= reg_wdata[`IBM_BIT_CAP0]; // RULE_02
        end
        large_block_mode[1] <= 1'b1; // RULE_12
      end
      else if (generic_ctrl_access)
        large_block_mode[1] <= 1'b0; // RULE_12
      if (wr_fifo)
      begin
        if (reg_be[1])
          wr_threshold <= reg_wdata[13:8]; // RULE_18
        if (reg_be[0])
          rd_threshold <= reg_wdata[5:0]; // RULE_19
      end
    end
  end
endmodule // ibm_dma_status

// *** design/ibm_fifo.v ***
`timescale 1ns/1ps
module ibm_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clk_sys,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push;
  wire pop;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always @(posedge clk_sys)
  begin
    if (!rst_n || flush)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        level <= level + 1'b1;
      else if (pop && !push)
        level <= level - 1'b1;
    end
  end
endmodule // ibm_fifo

// *** test/ibm_dma_status_assertions.sv ***
`timescale 1ns/1ps
module ibm_dma_status_assertions (
  input wire clk_sys,
  input wire rst_n,
  input wire reg_sel,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_rdata,
  input wire generic_ctrl_access,
  input wire [1:0] taskfile_access,
  input wire [1:0] target_abort,
  input wire [1:0] pci_owner,
  input wire [63:0] engine_address,
  input wire [31:0] engine_count,
  input wire [29:0] count_extension,
  input wire [1:0] last_descriptor_flag,
  input wire [1:0] engine_enable,
  input wire [1:0] large_block_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rd(a); reg_sel && !reg_wr && reg_addr == a; endsequence
  sequence wr_ctrl; reg_sel && reg_wr && reg_addr == 8'h18; endsequence
  a_simplex_zero: assert property (rd(8'h18) |=> !reg_rdata[23]) else $error("simplex bit set");
  a_active_idle: assert property (rd(8'h18) ##0 !engine_enable[1] ##0 !$past(engine_enable[1]) |=> !reg_rdata[16])
    else $error("active while off");
  a_abort_enabled: assert property (taskfile_access[1] |=> target_abort[1] == $past(engine_enable[1]))
    else $error("target abort wrong");
  a_addr_diag: assert property (rd(8'h28) |=> reg_rdata == $past(engine_address[63:32])) else $error("address wrong");
  a_count_diag: assert property (rd(8'h2c) |=> reg_rdata == {$past(last_descriptor_flag[1]),
    ($past(large_block_mode[1]) ? $past(count_extension[29:15]) : 15'h0000), $past(engine_count[31:16])})
    else $error("byte count wrong");
  a_block_mode: assert property (wr_ctrl ##0 !generic_ctrl_access |=> large_block_mode[1]) else $error("mode not set");
  a_generic_mode: assert property (generic_ctrl_access && !reg_sel |=> !large_block_mode[1]) else $error("mode kept");
  a_owner_onehot: assert property ($onehot0(pci_owner)) else $error("two owners");
endmodule // ibm_dma_status_assertions
bind ibm_dma_status ibm_dma_status_assertions u_chk (.*);

// *** test/ibm_partner.sv ***
`timescale 1ns/1ps
module ibm_partner (
  input wire clk_sys,
  input wire rst_n,
  input wire stall,
  input wire [1:0] dma_request,
  input wire [1:0] fifo_out_valid,
  output reg pci_grant,
  output reg [1:0] fifo_out_ready,
  output reg [7:0] popped
);
  // memory side grants a cycle late and sinks channel 1 only every other cycle, so it is never fast
  reg phase;
  always @(posedge clk_sys)
  begin
    phase <= rst_n & ~phase;
    pci_grant <= rst_n & (|dma_request);
    fifo_out_ready <= {rst_n & ~stall & phase, 1'b0};
    if (!rst_n)
      popped <= 8'h00;
    else if (fifo_out_valid[1] && fifo_out_ready[1])
      popped <= popped + 8'h01;
  end
endmodule // ibm_partner

// *** test/test_ibm_dma_status.sv ***
`timescale 1ns/1ps
module test_ibm_dma_status;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, generic_ctrl_access = 1'b0, stall = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0, engine_count = 32'h5a5a1234, d = 32'h0;
  logic [1:0] taskfile_access = 2'h0, drive_irq = 2'h0, watchdog_status = 2'h0, bus_error = 2'h0, dma_request = 2'h0;
  logic [1:0] last_descriptor_flag = 2'h2, transfer_done = 2'h0, fifo_in_valid = 2'h0;
  logic [63:0] engine_address = 64'h89abcdef01234567, fifo_in_data = 64'h0000002a00000000;
  logic [29:0] count_extension = {15'h7f01, 15'h0102};
  wire [31:0] reg_rdata;
  wire [63:0] fifo_out_data;
  wire [1:0] target_abort, pci_owner, stop_transaction, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  wire [1:0] engine_enable, transfer_direction, large_block_mode, request_priority;
  wire pci_grant;
  wire [7:0] popped;
  int mismatches = 0, tests_run = 0, i;
  ibm_dma_status #(.DEPTH(16), .AW(4)) dut (.*);
  ibm_partner u_far (.*);
  always #25 clk_sys = ~clk_sys;
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      mismatches++;
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
    {reg_sel, reg_wr, reg_addr, reg_wdata, reg_be} = {1'b1, w, a, v, be};
    tick(1);
    d = reg_rdata;
    reg_sel = 1'b0;
    tick(1);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task bail(input logic ok);
    chk("wait", 32'h1, ok);
    if (ok !== 1'b1)
      test_done;
  endtask
  task irq(input logic [1:0] v);
    drive_irq = v;
    tick(1);
  endtask
  task pulse_tf;
    taskfile_access = 2'b10;
    tick(1);
    taskfile_access = 2'b00;
  endtask
  task fill;
    fifo_in_valid = 2'b10;
    tick(20);
    fifo_in_valid = 2'b00;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task t_ctrl;
    rchk(8'h18, 32'h00080000);
    rchk(8'h30, 32'h00000000);
    acc(1'b1, 8'h18, 32'hffffffff, 4'hf);
    rchk(8'h18, 32'h00680009);
    chk("dir", 32'h1, transfer_direction[1]);
    watchdog_status = 2'b10;
    rchk(8'h18, 32'h00780009);
    pulse_tf;
    chk("abort on", 32'h1, target_abort[1]);
    acc(1'b1, 8'h18, 32'h0, 4'hf);
    watchdog_status = 2'b00;
    pulse_tf;
    chk("abort off", 32'h0, target_abort[1]);
    $display("t_ctrl done");
  endtask
  task t_irq;
    acc(1'b1, 8'h18, 32'h1, 4'h1);
    irq(2'b10);
    rchk(8'h18, 32'h000c0001);
    irq(2'b00);
    rchk(8'h18, 32'h000c0001);
    acc(1'b1, 8'h18, 32'h00040001, 4'h5);
    rchk(8'h18, 32'h00080001);
    acc(1'b1, 8'h18, 32'h0, 4'h1);
    irq(2'b10);
    rchk(8'h18, 32'h000c0000);
    irq(2'b00);
    rchk(8'h18, 32'h00080000);
    $display("t_irq done");
  endtask
  task t_fifo;
    acc(1'b1, 8'h18, 32'h9, 4'h1);
    fill;
    chk("in ready", 32'h0, fifo_in_ready[1]);
    irq(2'b10);
    rchk(8'h18, 32'h00000009);
    stall = 1'b0;
    for (i = 0; i < 100 && d[19] !== 1'b1; i++)
      acc(1'b0, 8'h18, 32'h0, 4'h0);
    bail(d[19]);
    chk("pops", 32'h10, popped);
    transfer_done = 2'b10;
    tick(1);
    rchk(8'h18, 32'h000c0009);
    transfer_done = 2'b00;
    irq(2'b00);
    stall = 1'b1;
    fill;
    acc(1'b1, 8'h18, 32'h00040000, 4'h5);
    stall = 1'b0;
    tick(40);
    rchk(8'h18, 32'h00080000);
    chk("discarded", 32'h10, popped);
    $display("t_fifo done");
  endtask
  task t_diag;
    generic_ctrl_access = 1'b1;
    tick(1);
    generic_ctrl_access = 1'b0;
    rchk(8'h20, 32'h01234567);
    rchk(8'h24, 32'h00001234);
    rchk(8'h28, 32'h89abcdef);
    rchk(8'h2c, 32'h80005a5a);
    acc(1'b1, 8'h18, 32'h0, 4'h0);
    rchk(8'h2c, 32'hff015a5a);
    $display("t_diag done");
  endtask
  task t_arb;
    acc(1'b1, 8'h40, 32'hffffffff, 4'hf);
    rchk(8'h40, 32'h00003f3f);
    chk("prio0 high thr", 32'h0, request_priority[0]);
    acc(1'b1, 8'h40, 32'h00003f00, 4'h1);
    chk("prio0 low thr", 32'h1, request_priority[0]);
    acc(1'b1, 8'h18, 32'h9, 4'h1);
    chk("prio1 empty", 32'h0, request_priority[1]);
    dma_request = 2'b11;
    for (i = 0; i < 20 && pci_owner === 2'b00; i++)
      tick(1);
    chk("owner", 32'h1, pci_owner);
    acc(1'b1, 8'h40, 32'h00003f3f, 4'h1);
    stall = 1'b1;
    fifo_in_valid = 2'b10;
    tick(1);
    fifo_in_valid = 2'b00;
    for (i = 0; i < 20 && stop_transaction[0] !== 1'b1; i++)
      tick(1);
    bail(stop_transaction[0]);
    tick(4);
    chk("owner", 32'h2, pci_owner);
    bus_error = 2'b10;
    tick(1);
    bus_error = 2'b00;
    rchk(8'h18, 32'h00030009);
    {transfer_done, dma_request, stall} = {2'b10, 2'b00, 1'b0};
    acc(1'b1, 8'h18, 32'h00020009, 4'h5);
    tick(10);
    rchk(8'h18, 32'h00080009);
    $display("t_arb done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_ctrl;
    t_irq;
    t_fifo;
    t_diag;
    t_arb;
    test_done;
  end
endmodule // test_ibm_dma_status
